/* hdl/swa_card_end.sv */
// Card module end of the single-wire link activation.
// Frame logic faces the link clock; timers and sequencing run on i_mclk.
//
// Behaviour
// - Line rise from off reruns activation handshake
// - Re-activation frames carry no info field
// - Front end stops after good re-activation sync
// - Front end raises line 1000 us after supply
// - Initial resume within 700 us of rise
// - Answer power frame within 2000 us
// - Abandon unanswered resume within 100 ms
// - Re-activation resume within 500 us
// - Front end repeat exceeds response plus resume; C_REPEAT gives 2500 us, short of 2000 plus 700 us
// - Low power forbids contact and USB activation; this end has no such gating, i_contact_active is taken in either power mode
// - Full power allows other interfaces freely
// - Contact-active card treats link as selection
// - Ground unsupported line within 2 s
// - Front end holds line low on failure
// - Return data only while line high
// - Front end activates by raising the line
// - Repeat bit one resends sync, zero ready
// - Stay silent on corrupted frame
// - At most three repeat power frames
`timescale 1ns/1ps
module swa_card_end #(
  parameter int unsigned P_RES_INIT = swa_pkg::C_RES_INIT,
  parameter int unsigned P_RES_REACT = swa_pkg::C_RES_REACT,
  parameter int unsigned P_FRP = swa_pkg::C_FRP,
  parameter int unsigned P_ABANDON = swa_pkg::C_ABANDON,
  parameter int unsigned P_GROUND = swa_pkg::C_GROUND
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  swa_link_if.device lnk,
  input wire logic i_app_ready,
  input wire logic i_contact_active,
  input wire logic i_term_no_swp,
  input wire logic i_line_tied_vcc,
  output swa_pkg::swa_dst_t o_state,
  output logic o_activated,
  output logic o_full_power,
  output logic o_app_selected,
  output logic o_inhibited,
  output logic o_grounded
);
  import swa_pkg::*;
  swa_dst_t state_ff;
  logic react_ff;
  logic rep_ff;
  logic act_ff;
  logic full_ff;
  logic sel_ff;
  logic gnd_ff;
  logic res_ff;
  logic tx_tgl_ff;
  swa_frm_t tx_type_ff;
  logic tx_info_ff;
  // Link domain
  logic rx_tgl_ff;
  swa_frm_t rx_type_ff;
  logic rx_fr_ff;
  logic rx_full_ff;
  logic rx_ok_ff;
  logic tx_s1_ff, tx_s2_ff, tx_s3_ff;
  logic lres_s1_ff, lres_s2_ff;
  logic dvld_ff;
  swa_frm_t dtype_ff;
  logic dinfo_ff;
  // Module clock synchronisers
  logic rx_s1_ff, rx_s2_ff, rx_s3_ff;
  logic ln_s1_ff, ln_s2_ff, ln_s3_ff;
  logic act_s1_ff, act_s2_ff;
  logic vcc_s1_ff, vcc_s2_ff;
  logic rx_evt, line_rise, line_fall;
  logic win_start, win_stop, win_done;
  logic inh_start, inh_stop, inh_done;
  logic gnd_run, gnd_done, gnd_tmr_busy;
  logic inh_ff;
  logic [TMR_W-1:0] win_load;

  // Frame capture on the link clock, handed over by toggle
  always_ff @(posedge lnk.link_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_tgl_ff <= 1'h0;
      rx_type_ff <= FRM_SYNC;
      rx_fr_ff <= 1'h0;
      rx_full_ff <= 1'h0;
      rx_ok_ff <= 1'h0;
    end else if (lnk.h_frm_vld) begin
      rx_tgl_ff <= ~rx_tgl_ff;
      rx_type_ff <= lnk.h_frm_type;
      rx_fr_ff <= lnk.h_frm_fr;
      rx_full_ff <= lnk.h_frm_full;
      rx_ok_ff <= lnk.h_frm_ok;
    end
  end

  // Outgoing frame and resume level on the link clock
  always_ff @(posedge lnk.link_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_s1_ff <= 1'h0;
      tx_s2_ff <= 1'h0;
      tx_s3_ff <= 1'h0;
      lres_s1_ff <= 1'h0;
      lres_s2_ff <= 1'h0;
      dvld_ff <= 1'h0;
      dtype_ff <= FRM_SYNC;
      dinfo_ff <= 1'h0;
    end else begin
      tx_s1_ff <= tx_tgl_ff;
      tx_s2_ff <= tx_s1_ff;
      tx_s3_ff <= tx_s2_ff;
      lres_s1_ff <= res_ff;
      lres_s2_ff <= lres_s1_ff;
      dvld_ff <= tx_s2_ff ^ tx_s3_ff;
      // Type and info held stable since the toggle flipped
      if (tx_s2_ff ^ tx_s3_ff) begin
        dtype_ff <= tx_type_ff;
        dinfo_ff <= tx_info_ff;
      end
    end
  end
  assign lnk.d_frm_vld = dvld_ff;
  assign lnk.d_frm_type = dtype_ff;
  assign lnk.d_frm_info = dinfo_ff;
  assign lnk.d_resume = lres_s2_ff;
  assign lnk.line_d_out = 1'h0;
  assign lnk.line_d_oe_n = ~gnd_ff;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rx_s1_ff <= 1'h0;
      rx_s2_ff <= 1'h0;
      rx_s3_ff <= 1'h0;
      ln_s1_ff <= 1'h0;
      ln_s2_ff <= 1'h0;
      ln_s3_ff <= 1'h0;
      act_s1_ff <= 1'h0;
      act_s2_ff <= 1'h0;
      vcc_s1_ff <= 1'h0;
      vcc_s2_ff <= 1'h0;
    end else begin
      rx_s1_ff <= rx_tgl_ff;
      rx_s2_ff <= rx_s1_ff;
      rx_s3_ff <= rx_s2_ff;
      ln_s1_ff <= lnk.line;
      ln_s2_ff <= ln_s1_ff;
      ln_s3_ff <= ln_s2_ff;
      act_s1_ff <= lnk.h_act;
      act_s2_ff <= act_s1_ff;
      vcc_s1_ff <= i_line_tied_vcc;
      vcc_s2_ff <= vcc_s1_ff;
    end
  end
  assign rx_evt = rx_s2_ff ^ rx_s3_ff;
  assign line_rise = ln_s2_ff & ~ln_s3_ff;
  assign line_fall = ~ln_s2_ff & ln_s3_ff;

  // Resume or response window; the two never overlap
  assign win_load = (state_ff == DS_OFF) ?
    TMR_W'(react_ff ? P_RES_REACT : P_RES_INIT) : TMR_W'(P_FRP);
  assign win_start = (state_ff == DS_OFF && line_rise) ||
    (state_ff == DS_WAIT_PM && rx_evt && rx_ok_ff && rx_type_ff == FRM_PWR);
  assign win_stop = line_fall;
  assign inh_start = (state_ff == DS_WAIT_RES) && (i_app_ready || win_done);
  // Armed as the resume step is taken, so not cleared there
  assign inh_stop = (state_ff != DS_RESUME) && (state_ff != DS_WAIT_RES);
  assign gnd_run = ~vcc_s2_ff & i_term_no_swp & ~gnd_ff;

  swa_timer #(.W(TMR_W)) u_win (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(win_start), .i_stop(win_stop),
    .i_load(win_load), .o_busy(), .o_done(win_done));
  swa_timer #(.W(TMR_W)) u_inh (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(inh_start), .i_stop(inh_stop),
    .i_load(TMR_W'(P_ABANDON)), .o_busy(), .o_done(inh_done));
  swa_timer #(.W(TMR_W)) u_gnd (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(gnd_run & ~gnd_tmr_busy),
    .i_stop(~gnd_run), .i_load(TMR_W'(P_GROUND)), .o_busy(gnd_tmr_busy),
    .o_done(gnd_done));

  // Activation sequencing
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= DS_OFF;
      react_ff <= 1'h0;
      rep_ff <= 1'h0;
      res_ff <= 1'h0;
      tx_tgl_ff <= 1'h0;
      tx_type_ff <= FRM_SYNC;
      tx_info_ff <= 1'h0;
    end else if (line_fall && state_ff != DS_OFF && state_ff != DS_INHIBIT) begin
      state_ff <= DS_OFF;
      react_ff <= 1'h1;
      res_ff <= 1'h0;
    end else begin
      case (state_ff)
        DS_OFF: if (line_rise && !gnd_ff) begin
          state_ff <= DS_WAIT_RES;
        end
        // Forced at window end so a slow application cannot miss it
        DS_WAIT_RES: if (i_app_ready || win_done) begin
          res_ff <= 1'h1;
          state_ff <= DS_RESUME;
        end
        DS_RESUME: if (act_s2_ff) begin
          state_ff <= DS_SYNC;
        end else if (inh_done) begin
          res_ff <= 1'h0;
          state_ff <= DS_INHIBIT;
        end
        DS_SYNC: if (ln_s2_ff) begin
          tx_tgl_ff <= ~tx_tgl_ff;
          tx_type_ff <= FRM_SYNC;
          tx_info_ff <= ~react_ff;
          state_ff <= DS_WAIT_PM;
        end
        DS_WAIT_PM: if (rx_evt && rx_ok_ff && rx_type_ff == FRM_PWR) begin
          rep_ff <= rx_fr_ff;
          state_ff <= DS_RESPOND;
        end
        DS_RESPOND: if ((i_app_ready || win_done) && ln_s2_ff) begin
          tx_tgl_ff <= ~tx_tgl_ff;
          tx_type_ff <= rep_ff ? FRM_SYNC : FRM_READY;
          tx_info_ff <= ~react_ff;
          state_ff <= rep_ff ? DS_WAIT_PM : DS_ACTIVE;
        end
        // Corrupt or unexpected frames fall through unanswered
        DS_ACTIVE: state_ff <= DS_ACTIVE;
        DS_INHIBIT: state_ff <= DS_INHIBIT;
        default: state_ff <= DS_OFF;
      endcase
    end
  end

  // Status and power mode
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      act_ff <= 1'h0;
      full_ff <= 1'h0;
      sel_ff <= 1'h0;
    end else if (line_fall) begin
      act_ff <= 1'h0;
      sel_ff <= 1'h0;
    end else begin
      if (state_ff == DS_SYNC && ln_s2_ff) begin
        act_ff <= 1'h1;
        sel_ff <= i_contact_active;
      end
      if (rx_evt && rx_ok_ff && rx_type_ff == FRM_PWR) begin
        full_ff <= rx_full_ff;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gnd_ff <= 1'h0;
    end else if (gnd_done) begin
      gnd_ff <= 1'h1;
    end
  end

  // Registered status pin, one cycle behind the state
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      inh_ff <= 1'h0;
    end else begin
      inh_ff <= (state_ff == DS_INHIBIT);
    end
  end

  assign o_state = state_ff;
  assign o_activated = act_ff;
  assign o_full_power = full_ff;
  assign o_app_selected = sel_ff;
  assign o_inhibited = inh_ff;
  assign o_grounded = gnd_ff;
endmodule

/* hdl/swa_pkg.sv */
// Shared constants and types for the single-wire link activation ends.
// Assumes a 200 MHz module clock on both ends.
package swa_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TMR_W = 32;
  // Times as printed
  localparam int unsigned T_RAISE_US = 1000;
  localparam int unsigned T_RES_INIT_US = 700;
  localparam int unsigned T_RES_REACT_US = 500;
  localparam int unsigned T_FRP_US = 2000;
  localparam int unsigned T_ABANDON_MS = 100;
  localparam int unsigned T_GROUND_S = 2;
  localparam int unsigned T_REPEAT_US = 2500;
  // Cycle counts at the module clock
  localparam int unsigned C_RAISE = T_RAISE_US * CLK_MHZ;
  localparam int unsigned C_RES_INIT = T_RES_INIT_US * CLK_MHZ;
  localparam int unsigned C_RES_REACT = T_RES_REACT_US * CLK_MHZ;
  localparam int unsigned C_FRP = T_FRP_US * CLK_MHZ;
  localparam int unsigned C_ABANDON = T_ABANDON_MS * 1000 * CLK_MHZ;
  localparam int unsigned C_GROUND = T_GROUND_S * 1000000 * CLK_MHZ;
  localparam int unsigned C_REPEAT = T_REPEAT_US * CLK_MHZ;
  localparam int unsigned LINK_HALF = 12;
  localparam int unsigned MAX_FR_REPEAT = 3;
  typedef enum logic [1:0] {FRM_SYNC, FRM_PWR, FRM_READY} swa_frm_t;
  typedef enum logic [2:0] {DS_OFF, DS_WAIT_RES, DS_RESUME, DS_SYNC, DS_WAIT_PM,
    DS_RESPOND, DS_ACTIVE, DS_INHIBIT} swa_dst_t;
  typedef enum logic [2:0] {HS_OFF, HS_RAISE, HS_WAIT_RES, HS_WAIT_SYNC,
    HS_WAIT_RSP, HS_ACTIVE, HS_FAIL} swa_hst_t;
endpackage

/* hdl/swa_link_if.sv */
// Single-wire line plus frame-level link between front end and card module.
// Line level is resolved here from both ends' drive enables.
`timescale 1ns/1ps
interface swa_link_if;
  import swa_pkg::*;
  logic link_clk;
  logic line_h_out;
  logic line_h_oe_n;
  logic line_d_out;
  logic line_d_oe_n;
  logic line;
  logic h_frm_vld;
  swa_frm_t h_frm_type;
  logic h_frm_fr;
  logic h_frm_full;
  logic h_frm_ok;
  logic h_act;
  logic d_resume;
  logic d_frm_vld;
  swa_frm_t d_frm_type;
  logic d_frm_info;
  // Card grounding wins over master drive
  assign line = !line_d_oe_n ? line_d_out : (!line_h_oe_n ? line_h_out : 1'h0);
  modport device(input link_clk, line, h_frm_vld, h_frm_type, h_frm_fr, h_frm_full,
    h_frm_ok, h_act, output line_d_out, line_d_oe_n, d_resume, d_frm_vld,
    d_frm_type, d_frm_info);
  modport host(output link_clk, line_h_out, line_h_oe_n, h_frm_vld, h_frm_type,
    h_frm_fr, h_frm_full, h_frm_ok, h_act, input line, d_resume, d_frm_vld,
    d_frm_type, d_frm_info);
endinterface

/* hdl/swa_timer.sv */
// One-shot down counter on the module clock.
// Assumes start and stop are single-clock-domain controls.
`timescale 1ns/1ps
module swa_timer #(
  parameter int W = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [W-1:0] i_load,
  output logic o_busy,
  output logic o_done
);
  import swa_pkg::*;
  logic [W-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      busy_ff <= 1'h0;
      done_ff <= 1'h0;
    end else if (i_stop) begin
      busy_ff <= 1'h0;
      done_ff <= 1'h0;
    end else if (i_start) begin
      cnt_ff <= i_load;
      busy_ff <= 1'h1;
      done_ff <= 1'h0;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - 1'h1;
      if (cnt_ff <= 1) begin
        busy_ff <= 1'h0;
        done_ff <= 1'h1;
      end
    end
  end
  assign o_busy = busy_ff;
  assign o_done = done_ff;
endmodule

/* hdl/swa_reader_end.sv */
// Front-end (link master) end of the single-wire link activation.
// Makes the link clock by dividing i_mclk; device frames are sampled mid-period.
`timescale 1ns/1ps
module swa_reader_end #(
  parameter int unsigned P_RAISE = swa_pkg::C_RAISE,
  parameter int unsigned P_RES_WAIT = swa_pkg::C_RES_INIT,
  parameter int unsigned P_REPEAT = swa_pkg::C_REPEAT
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  swa_link_if.host lnk,
  input wire logic i_vcc_on,
  input wire logic i_full_power,
  input wire logic i_deact,
  output swa_pkg::swa_hst_t o_state,
  output logic o_activated,
  output logic o_no_support
);
  import swa_pkg::*;
  swa_hst_t state_ff;
  logic [7:0] div_ff;
  logic clk_ff;
  logic line_ff;
  logic act_ff;
  logic react_ff;
  logic raised_ff;
  logic [1:0] frcnt_ff;
  logic pend_ff;
  logic pfr_ff;
  logic vld_ff;
  logic fr_ff;
  logic full_ff;
  logic actv_ff;
  logic nosup_ff;
  logic fall_evt;
  logic t_start, t_done;
  logic [TMR_W-1:0] t_load;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 8'h00;
      clk_ff <= 1'h0;
    end else if (div_ff == 8'(LINK_HALF - 1)) begin
      div_ff <= 8'h00;
      clk_ff <= ~clk_ff;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end
  // Falling moment: device outputs are settled, frame fields may change
  assign fall_evt = (div_ff == 8'(LINK_HALF - 1)) && clk_ff;

  // Frame fields span exactly one rising link edge
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      vld_ff <= 1'h0;
      fr_ff <= 1'h0;
      full_ff <= 1'h0;
    end else if (fall_evt) begin
      vld_ff <= pend_ff && !vld_ff;
      // Power mode frozen for the whole frame
      if (pend_ff && !vld_ff) begin
        fr_ff <= pfr_ff;
        full_ff <= i_full_power;
      end
    end
  end

  assign t_start = (state_ff == HS_OFF && i_vcc_on && !raised_ff) ||
    (state_ff == HS_RAISE && t_done) ||
    (fall_evt && lnk.d_resume && state_ff == HS_WAIT_RES) ||
    (pend_ff && fall_evt && !vld_ff);
  assign t_load = (state_ff == HS_OFF) ? TMR_W'(P_RAISE) :
    (state_ff == HS_RAISE) ? TMR_W'(P_RES_WAIT) : TMR_W'(P_REPEAT);
  swa_timer #(.W(TMR_W)) u_tmr (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_start(t_start),
    .i_stop(state_ff == HS_ACTIVE || state_ff == HS_FAIL), .i_load(t_load),
    .o_busy(), .o_done(t_done));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= HS_OFF;
      line_ff <= 1'h0;
      act_ff <= 1'h0;
      react_ff <= 1'h0;
      raised_ff <= 1'h0;
      frcnt_ff <= 2'h0;
      pend_ff <= 1'h0;
      pfr_ff <= 1'h0;
    end else begin
      if (pend_ff && fall_evt && !vld_ff) begin
        pend_ff <= 1'h0;
      end
      case (state_ff)
        HS_OFF: if (i_vcc_on && raised_ff && react_ff && !i_deact) begin
          line_ff <= 1'h1;
          state_ff <= HS_WAIT_RES;
        end else if (i_vcc_on && !raised_ff) begin
          state_ff <= HS_RAISE;
        end
        HS_RAISE: if (t_done) begin
          line_ff <= 1'h1;
          raised_ff <= 1'h1;
          state_ff <= HS_WAIT_RES;
        end
        HS_WAIT_RES: if (fall_evt && lnk.d_resume) begin
          act_ff <= 1'h1;
          state_ff <= HS_WAIT_SYNC;
        end else if (t_done) begin
          state_ff <= HS_FAIL;
        end
        HS_WAIT_SYNC: if (fall_evt && lnk.d_frm_vld) begin
          if (react_ff || !i_full_power) begin
            state_ff <= HS_ACTIVE;
          end else begin
            pend_ff <= 1'h1;
            pfr_ff <= 1'h0;
            state_ff <= HS_WAIT_RSP;
          end
        end
        HS_WAIT_RSP: if (fall_evt && lnk.d_frm_vld) begin
          state_ff <= HS_ACTIVE;
        end else if (t_done && !pend_ff) begin
          if (frcnt_ff == 2'(MAX_FR_REPEAT)) begin
            state_ff <= HS_FAIL;
          end else begin
            frcnt_ff <= frcnt_ff + 2'h1;
            pend_ff <= 1'h1;
            pfr_ff <= 1'h1;
          end
        end
        HS_ACTIVE: if (i_deact) begin
          line_ff <= 1'h0;
          act_ff <= 1'h0;
          react_ff <= 1'h1;
          frcnt_ff <= 2'h0;
          state_ff <= HS_OFF;
        end
        HS_FAIL: begin
          line_ff <= 1'h0;
          act_ff <= 1'h0;
        end
        default: state_ff <= HS_OFF;
      endcase
    end
  end

  assign lnk.link_clk = clk_ff;
  assign lnk.line_h_out = line_ff;
  assign lnk.line_h_oe_n = 1'h0;
  assign lnk.h_frm_vld = vld_ff;
  assign lnk.h_frm_type = FRM_PWR;
  assign lnk.h_frm_fr = fr_ff;
  assign lnk.h_frm_full = full_ff;
  assign lnk.h_frm_ok = 1'h1;
  assign lnk.h_act = act_ff;
  // Status pins registered, one cycle behind the state
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      actv_ff <= 1'h0;
      nosup_ff <= 1'h0;
    end else begin
      actv_ff <= (state_ff == HS_ACTIVE);
      nosup_ff <= (state_ff == HS_FAIL);
    end
  end
  assign o_state = state_ff;
  assign o_activated = actv_ff;
  assign o_no_support = nosup_ff;
endmodule

/* test/swa_link_assertions.sv */
// Checks on the link joining the reader end and the card end.
// Assumes both ends are design modules sharing one link interface.
`timescale 1ns/1ps
module swa_link_assertions
  import swa_pkg::*;
(
  input wire logic link_clk,
  input wire logic i_rst,
  input wire logic line,
  input wire logic h_frm_vld,
  input wire logic h_frm_fr,
  input wire logic h_act,
  input wire logic d_resume,
  input wire logic d_frm_vld,
  input wire swa_frm_t d_frm_type,
  input wire logic d_frm_info
);
  // Bounds in link cycles, with slack for synchronisers
  localparam int RES_MAX = 30;
  localparam int ANS_MAX = 40;
  logic hi_ff;
  logic react_ff;
  logic [2:0] rep_ff;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (i_rst);
  // Any line fall makes the next rise a reactivation
  always_ff @(posedge link_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_ff <= 1'h0;
      react_ff <= 1'h0;
    end else begin
      hi_ff <= line;
      if (hi_ff && !line) begin
        react_ff <= 1'h1;
      end
    end
  end
  always_ff @(posedge link_clk or posedge i_rst) begin
    if (i_rst) begin
      rep_ff <= 3'h0;
    end else if (!line) begin
      rep_ff <= 3'h0;
    end else if (h_frm_vld && h_frm_fr && rep_ff != 3'h7) begin
      rep_ff <= rep_ff + 3'h1;
    end
  end
  no_tx_low_a: assert property (!line [*4] |-> !d_frm_vld)
    else $error("card frame while line low");
  react_info_a: assert property (d_frm_vld && react_ff |-> !d_frm_info)
    else $error("info field in reactivation frame");
  first_info_a: assert property (
    d_frm_vld && d_frm_type == FRM_SYNC && !react_ff |-> d_frm_info)
    else $error("info field missing in first sync");
  resume_bound_a: assert property ($rose(line) |-> ##[1:RES_MAX] d_resume)
    else $error("resume late after line rise");
  resume_ack_a: assert property ($rose(d_resume) |-> ##[0:4] h_act)
    else $error("resume not acknowledged");
  react_stop_a: assert property (d_frm_vld && react_ff |=> !h_frm_vld [*8])
    else $error("reader frame after reactivation sync");
  ready_ans_a: assert property (
    h_frm_vld && !h_frm_fr |-> ##[1:ANS_MAX] d_frm_vld && d_frm_type == FRM_READY)
    else $error("no ready answer to power frame");
  repeat_max_a: assert property (rep_ff <= 3'h3)
    else $error("too many repeat requests");
  ready_c: cover property (d_frm_vld && d_frm_type == FRM_READY);
  react_c: cover property (d_frm_vld && react_ff);
  ack_c: cover property (d_resume && h_act);
endmodule

/* test/swp_interface_activation_tb_top.sv */
// Bench: reader and card ends joined, plus a second card driven here.
// Assumes the shared package and link interface of the design.
`timescale 1ns/1ps
module swp_interface_activation_tb_top;
  import swa_pkg::*;
  // Shortened windows, in module clock cycles
  localparam int RI = 200, RR = 150, FP = 300, AB = 2000, GR = 500;
  logic i_mclk = 0, i_rst = 1;
  logic vcc = 0, fpw = 0, deact = 0, app1 = 1, app2 = 0, cont = 0;
  logic nosw = 0, tied = 1, react = 0;
  logic r_act, c1_act, c1_full, c1_sel, c2_act, c2_full, c2_sel, c2_inh, c2_gnd;
  logic r_nosup;
  swa_hst_t r_st;
  swa_dst_t c1_st, c2_st;
  int fail_count = 0, tests_run = 0, k, nfr = 0, n0;
  logic [31:0] rs = 32'h4f;
  logic [3:0] e;
  logic [3:0] exp_q[$];
  swa_link_if lk ();
  swa_link_if lk2 ();
  swa_reader_end #(.P_RAISE(100), .P_RES_WAIT(400), .P_REPEAT(600)) i_swa_reader_end (
    .i_mclk, .i_rst, .lnk(lk.host), .i_vcc_on(vcc), .i_full_power(fpw),
    .i_deact(deact), .o_state(r_st), .o_activated(r_act), .o_no_support(r_nosup));
  swa_card_end #(.P_RES_INIT(RI), .P_RES_REACT(RR), .P_FRP(FP), .P_ABANDON(AB),
    .P_GROUND(GR)) i_swa_card_end (.i_mclk, .i_rst, .lnk(lk.device),
    .i_app_ready(app1), .i_contact_active(cont), .i_term_no_swp(1'b0),
    .i_line_tied_vcc(1'b0), .o_state(c1_st), .o_activated(c1_act), .o_full_power(c1_full),
    .o_app_selected(c1_sel), .o_inhibited(), .o_grounded());
  swa_card_end #(.P_RES_INIT(RI), .P_RES_REACT(RR), .P_FRP(FP), .P_ABANDON(AB),
    .P_GROUND(GR)) i_swa_card_end2 (.i_mclk, .i_rst, .lnk(lk2.device),
    .i_app_ready(app2), .i_contact_active(cont), .i_term_no_swp(nosw),
    .i_line_tied_vcc(tied), .o_state(c2_st), .o_activated(c2_act), .o_full_power(c2_full),
    .o_app_selected(c2_sel), .o_inhibited(c2_inh), .o_grounded(c2_gnd));
  swa_link_assertions i_swa_link_assertions (.link_clk(lk.link_clk), .i_rst(i_rst),
    .line(lk.line), .h_frm_vld(lk.h_frm_vld), .h_frm_fr(lk.h_frm_fr), .h_act(lk.h_act),
    .d_resume(lk.d_resume), .d_frm_vld(lk.d_frm_vld), .d_frm_type(lk.d_frm_type),
    .d_frm_info(lk.d_frm_info));
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Bench link clock stands still while the bench drive line_h_out is low
  initial begin
    lk2.link_clk = 0;
    forever #62.5 lk2.link_clk = lk2.line_h_out & ~lk2.link_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input logic [3:0] s, input logic [3:0] x, input string n);
    tests_run++;
    if (s !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic rst();
    @(posedge i_mclk);
    i_rst <= 1;
    lk2.h_act <= 0;
    lk2.line_h_out <= 0;
    react = 0;
    exp_q.delete();
    cyc(5);
    i_rst <= 0;
  endtask
  task automatic wact();
    for (k = 0; k < 3000 && r_act !== 1'b1; k++) cyc(1);
    cyc(100);
    chk(4'(r_act), 4'h1, "reader active");
    chk(4'(r_st), 4'(HS_ACTIVE), "reader state");
    chk(4'(r_nosup), 4'h0, "no support");
  endtask
  // Model: each good power frame expects one answer frame
  task automatic send(input logic fr, input logic ok);
    @(posedge lk2.link_clk);
    lk2.h_frm_vld <= 1;
    lk2.h_frm_fr <= fr;
    lk2.h_frm_ok <= ok;
    lk2.h_frm_full <= rs[3];
    if (ok) exp_q.push_back(fr ? 4'(FRM_SYNC) : 4'(FRM_READY));
    @(posedge lk2.link_clk);
    lk2.h_frm_vld <= 0;
    cyc(FP + 200);
    chk(4'(exp_q.size()), 4'h0, "answer frame");
  endtask
  task automatic up2(input int win, input logic ack);
    @(posedge i_mclk);
    lk2.line_h_out <= 1;
    // Resume flops are stale until the stopped link clock runs again
    cyc(60);
    for (k = 0; k < win + 40 && lk2.d_resume !== 1'b1; k++) cyc(1);
    chk(4'(lk2.d_resume), 4'h1, "resume");
    if (ack) begin
      exp_q.push_back(4'(FRM_SYNC));
      @(posedge lk2.link_clk);
      lk2.h_act <= 1;
      for (k = 0; k < 400 && c2_act !== 1'b1; k++) cyc(1);
      chk(4'(c2_act), 4'h1, "card2 active");
      cyc(150);
      chk(4'(exp_q.size()), 4'h0, "sync frame");
    end else begin
      for (k = 0; k < AB + 100 && c2_inh !== 1'b1; k++) cyc(1);
      chk(4'(c2_inh), 4'h1, "inhibit");
      cyc(80);
      chk(4'(lk2.d_resume), 4'h0, "resume dropped");
    end
  endtask
  always @(posedge lk2.link_clk) begin
    if (lk2.d_frm_vld === 1'b1) begin
      nfr++;
      e = exp_q.size() > 0 ? exp_q.pop_front() : 4'hf;
      chk(4'(lk2.d_frm_type), e, "frame type");
      if (e == 4'(FRM_SYNC)) chk(4'(lk2.d_frm_info), 4'(!react), "info field");
    end
  end
  initial begin
    #300000;
    fail_count++;
    summarize();
  end
  initial begin
    lk2.line_h_out = 0;
    lk2.line_h_oe_n = 0;
    lk2.h_frm_vld = 0;
    lk2.h_frm_type = FRM_PWR;
    lk2.h_frm_fr = 0;
    lk2.h_frm_full = 0;
    lk2.h_frm_ok = 1;
    lk2.h_act = 0;
    rst();
    rs = xs(rs);
    cont <= rs[0];
    fpw <= 1;
    vcc <= 1;
    cyc(90);
    chk(4'(lk.line), 4'h0, "early raise");
    wact();
    chk(4'(c1_act), 4'h1, "card1 active");
    chk(4'(c1_full), 4'h1, "full power");
    chk(4'(c1_sel), 4'(cont), "selection");
    chk(4'(c1_st), 4'(DS_ACTIVE), "card1 state");
    $display("test initial done");
    deact <= 1;
    cyc(200);
    chk(4'(c1_act), 4'h0, "card1 off");
    deact <= 0;
    wact();
    chk(4'(c1_act), 4'h1, "card1 again");
    $display("test reactivation done");
    rst();
    fpw <= 0;
    wact();
    chk(4'(c1_full), 4'h0, "low power");
    chk(4'(c1_st), 4'(DS_WAIT_PM), "card1 waits");
    $display("test low power done");
    up2(RI, 1'b0);
    $display("test abandon done");
    rst();
    rs = xs(rs);
    cont <= rs[0];
    up2(RI, 1'b1);
    chk(4'(c2_sel), 4'(cont), "card2 selection");
    n0 = nfr;
    send(1'b1, 1'b0);
    chk(4'(nfr - n0), 4'h0, "silent on corrupt");
    rs = xs(rs);
    send(1'b1, 1'b1);
    chk(4'(c2_full), 4'(rs[3]), "card2 power");
    send(1'b0, 1'b1);
    @(posedge lk2.link_clk);
    lk2.h_act <= 0;
    lk2.line_h_out <= 0;
    cyc(50);
    react = 1;
    up2(RR, 1'b1);
    $display("test card frames done");
    nosw <= 1;
    cyc(GR + 100);
    chk(4'(c2_gnd), 4'h0, "tied line kept");
    tied <= 0;
    cyc(GR + 100);
    chk(4'(c2_gnd), 4'h1, "grounded");
    chk(4'(lk2.line_d_oe_n), 4'h0, "ground drive");
    chk(4'(lk2.line), 4'h0, "line low");
    chk(4'(c2_st), 4'(DS_OFF), "card2 off");
    chk(4'(exp_q.size()), 4'h0, "frames left");
    $display("test grounding done");
    summarize();
  end
endmodule
